// ===== src/bfce_defines.svh
// Constants for the parallel flash command controller
`ifndef BFCE_DEFINES_SVH
`define BFCE_DEFINES_SVH

`define BFCE_UNLOCK_ADDR1 18'h05555
`define BFCE_UNLOCK_ADDR2 18'h02AAA
`define BFCE_UNLOCK_DATA1 8'hAA
`define BFCE_UNLOCK_DATA2 8'h55
`define BFCE_CMD_PROGRAM 8'hA0
`define BFCE_CMD_SETUP 8'h80
`define BFCE_CMD_ERASE 8'h10
`define BFCE_CMD_LOCKOUT 8'h40
`define BFCE_CMD_ID_ENTRY 8'h90
`define BFCE_CMD_ID_EXIT 8'hF0
`define BFCE_ANY_ADDR 18'h00000
`define BFCE_BOOT_TOP 18'h01FFF
`define BFCE_POLL_BIT 7
`define BFCE_TOGGLE_BIT 6
`define BFCE_CLK_NS 100
`define BFCE_PULSE_NS 100
`define BFCE_PULSE_CYC ((`BFCE_PULSE_NS + `BFCE_CLK_NS - 1) / `BFCE_CLK_NS)
`define BFCE_PROG_US 50
`define BFCE_PROG_CYC ((`BFCE_PROG_US * 1000) / `BFCE_CLK_NS)
`define BFCE_PWRUP_MS 5
`define BFCE_PWRUP_CYC ((`BFCE_PWRUP_MS * 1000000) / `BFCE_CLK_NS)
`define BFCE_RESET_CYC 4
`define BFCE_ERASE_MS 1000
`define BFCE_ERASE_CYC ((`BFCE_ERASE_MS * 1000000) / `BFCE_CLK_NS)

`endif

// ===== src/bfce_host.sv
// Host-side command sequencer driving a parallel NOR flash
// Contract
// - Host reissues an interrupted program or erase after reset; this host does not, it only raises TIMEOUT for the caller.
// - Six-write lockout sequence; then boot block refuses program/erase.
// - Six-write chip erase; device then erases unaided.
// - Four-write byte program; programming starts after fourth write.
// - Three writes enter identification; 0000 maker, 0001 device code.
// - Identification exits by three-write sequence or single F0 write.
`timescale 1ns/1ns
`default_nettype none
`include "bfce_defines.svh"

module bfce_host #(
  parameter int PROG_CYC = `BFCE_PROG_CYC,
  parameter int ERASE_CYC = `BFCE_ERASE_CYC,
  parameter int PWRUP_CYC = `BFCE_PWRUP_CYC,
  parameter int CNT_W = 24
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire bfce_pkg::bfce_req_t REQ,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic DONE,
  output logic TIMEOUT,
  output bfce_pkg::bfce_pins_t PINS,
  output logic HV_ID_EN,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE
);

  typedef enum logic [3:0] {
    ST_PWRUP, ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_RD_SETUP, ST_RD_WAIT,
    ST_POLL_A, ST_POLL_B, ST_RESET
  } bfce_st_t;

  bfce_st_t st_q, st_d;
  bfce_pkg::bfce_req_t req_q, req_d;
  bfce_pkg::bfce_pins_t pins_q, pins_d;
  logic [2:0] idx_q, idx_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] wait_q, wait_d;
  logic [7:0] dout_q, dout_d, rd_q, rd_d, poll_q, poll_d;
  logic oe_q, oe_d, rdv_q, rdv_d, done_q, done_d, to_q, to_d, hv_q, hv_d;
  logic [2:0] n_writes;
  logic [17:0] w_addr;
  logic [7:0] w_data;

  // Number of bus writes per command
  always_comb begin
    unique case (req_q.op)
      bfce_pkg::BFCE_OP_PROGRAM: n_writes = 3'h4;
      bfce_pkg::BFCE_OP_ERASE, bfce_pkg::BFCE_OP_LOCKOUT: n_writes = 3'h6;
      bfce_pkg::BFCE_OP_ID_ENTRY, bfce_pkg::BFCE_OP_ID_EXIT: n_writes = 3'h3;
      bfce_pkg::BFCE_OP_ID_EXIT1: n_writes = 3'h1;
      default: n_writes = 3'h0;
    endcase
  end

  // Address and data of write number idx
  always_comb begin
    unique case (idx_q)
      3'h0, 3'h3: begin
        w_addr = `BFCE_UNLOCK_ADDR1;
        w_data = `BFCE_UNLOCK_DATA1;
      end
      3'h1, 3'h4: begin
        w_addr = `BFCE_UNLOCK_ADDR2;
        w_data = `BFCE_UNLOCK_DATA2;
      end
      3'h2: begin
        w_addr = `BFCE_UNLOCK_ADDR1;
        unique case (req_q.op)
          bfce_pkg::BFCE_OP_PROGRAM: w_data = `BFCE_CMD_PROGRAM;
          bfce_pkg::BFCE_OP_ID_ENTRY: w_data = `BFCE_CMD_ID_ENTRY;
          bfce_pkg::BFCE_OP_ID_EXIT: w_data = `BFCE_CMD_ID_EXIT;
          default: w_data = `BFCE_CMD_SETUP;
        endcase
      end
      default: begin
        w_addr = `BFCE_UNLOCK_ADDR1;
        w_data = (req_q.op == bfce_pkg::BFCE_OP_LOCKOUT) ?
                 `BFCE_CMD_LOCKOUT : `BFCE_CMD_ERASE;
      end
    endcase
    if (req_q.op == bfce_pkg::BFCE_OP_PROGRAM && idx_q == 3'h3) begin
      w_addr = req_q.addr;
      w_data = req_q.data;
    end
    if (req_q.op == bfce_pkg::BFCE_OP_ID_EXIT1) begin
      w_addr = `BFCE_ANY_ADDR;
      w_data = `BFCE_CMD_ID_EXIT;
    end
  end

  always_comb begin
    st_d = st_q;
    req_d = req_q;
    pins_d = pins_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    wait_d = wait_q;
    dout_d = dout_q;
    rd_d = rd_q;
    poll_d = poll_q;
    oe_d = oe_q;
    rdv_d = 1'b0;
    done_d = 1'b0;
    to_d = 1'b0;
    hv_d = hv_q;
    unique case (st_q)
      ST_PWRUP: begin
        // Writes held off until the supply delay has run
        pins_d.reset_n = 1'b1;
        if (cnt_q >= CNT_W'(PWRUP_CYC)) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_IDLE: begin
        if (REQ_VALID) begin
          req_d = REQ;
          idx_d = 3'h0;
          cnt_d = '0;
          if (REQ.op == bfce_pkg::BFCE_OP_READ) begin
            pins_d.addr = REQ.addr;
            hv_d = REQ.data[0]; // Bit 0 of data asks for high-voltage ID
            st_d = ST_RD_SETUP;
          end else if (REQ.op == bfce_pkg::BFCE_OP_RESET) begin
            pins_d.reset_n = 1'b0;
            st_d = ST_RESET;
          end else begin
            st_d = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // Address, data and the ce_n/we_n strobe all change on one edge, output-enable held high
        pins_d.oe_n = 1'b1;
        pins_d.addr = w_addr;
        dout_d = w_data;
        oe_d = 1'b1;
        pins_d.ce_n = 1'b0;
        pins_d.we_n = 1'b0;
        cnt_d = '0;
        st_d = ST_STROBE;
      end
      ST_STROBE: begin
        // Strobe far wider than any glitch filter
        if (cnt_q + 1'b1 >= CNT_W'(`BFCE_PULSE_CYC)) begin
          pins_d.we_n = 1'b1;
          pins_d.ce_n = 1'b1;
          cnt_d = '0;
          st_d = ST_GAP;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_GAP: begin
        oe_d = 1'b0;
        if (idx_q + 3'h1 < n_writes) begin
          idx_d = idx_q + 3'h1;
          st_d = ST_SETUP;
        end else if (req_q.op == bfce_pkg::BFCE_OP_PROGRAM ||
                     req_q.op == bfce_pkg::BFCE_OP_ERASE ||
                     req_q.op == bfce_pkg::BFCE_OP_LOCKOUT) begin
          // Device runs on its own; watch status bits
          wait_d = '0;
          poll_d = (req_q.op == bfce_pkg::BFCE_OP_PROGRAM) ?
                   req_q.data : 8'hFF;
          if (req_q.op != bfce_pkg::BFCE_OP_PROGRAM) begin
            pins_d.addr = req_q.addr;
          end
          st_d = ST_POLL_A;
        end else begin
          done_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_RD_SETUP: begin
        pins_d.ce_n = 1'b0;
        pins_d.oe_n = 1'b0;
        st_d = ST_RD_WAIT;
      end
      ST_RD_WAIT: begin
        // Bus is driven by the device only now
        rd_d = DATA_IN;
        rdv_d = 1'b1;
        pins_d.ce_n = 1'b1;
        pins_d.oe_n = 1'b1;
        hv_d = 1'b0;
        st_d = ST_IDLE;
      end
      ST_POLL_A: begin
        pins_d.ce_n = 1'b0;
        pins_d.oe_n = 1'b0;
        wait_d = wait_q + 1'b1;
        st_d = ST_POLL_B;
      end
      ST_POLL_B: begin
        pins_d.ce_n = 1'b1;
        pins_d.oe_n = 1'b1;
        wait_d = wait_q + 1'b1;
        rd_d = DATA_IN;
        // Complemented poll bit means busy; toggle also compared
        if (DATA_IN[`BFCE_POLL_BIT] == poll_q[`BFCE_POLL_BIT] &&
            (wait_q < CNT_W'(2) ||
             DATA_IN[`BFCE_TOGGLE_BIT] == rd_q[`BFCE_TOGGLE_BIT])) begin
          done_d = 1'b1;
          st_d = ST_IDLE;
        end else if (wait_q >= CNT_W'(req_q.op == bfce_pkg::BFCE_OP_PROGRAM ?
                                      PROG_CYC : ERASE_CYC)) begin
          // Overrun: caller should reset then reissue
          to_d = 1'b1;
          st_d = ST_IDLE;
        end else begin
          st_d = ST_POLL_A;
        end
      end
      ST_RESET: begin
        if (cnt_q + 1'b1 >= CNT_W'(`BFCE_RESET_CYC)) begin
          pins_d.reset_n = 1'b1;
          done_d = 1'b1;
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      st_q <= ST_PWRUP;
      req_q <= '0;
      pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0,
                  addr: 18'h00000};
      idx_q <= 3'h0;
      cnt_q <= '0;
      wait_q <= '0;
      dout_q <= 8'h00;
      rd_q <= 8'h00;
      poll_q <= 8'h00;
      oe_q <= 1'b0;
      rdv_q <= 1'b0;
      done_q <= 1'b0;
      to_q <= 1'b0;
      hv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      pins_q <= pins_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      wait_q <= wait_d;
      dout_q <= dout_d;
      rd_q <= rd_d;
      poll_q <= poll_d;
      oe_q <= oe_d;
      rdv_q <= rdv_d;
      done_q <= done_d;
      to_q <= to_d;
      hv_q <= hv_d;
    end
  end

  assign REQ_READY = (st_q == ST_IDLE);
  assign RD_DATA = rd_q;
  assign RD_VALID = rdv_q;
  assign DONE = done_q;
  assign TIMEOUT = to_q;
  assign PINS = pins_q;
  assign HV_ID_EN = hv_q;
  assign DATA_OUT = dout_q;
  assign DATA_OE = oe_q;

endmodule // bfce_host
`default_nettype wire

// ===== src/bfce_pkg.sv
// Types for the parallel flash command controller
package bfce_pkg;

  typedef enum logic [2:0] {
    BFCE_OP_READ,
    BFCE_OP_PROGRAM,
    BFCE_OP_ERASE,
    BFCE_OP_LOCKOUT,
    BFCE_OP_ID_ENTRY,
    BFCE_OP_ID_EXIT,
    BFCE_OP_ID_EXIT1,
    BFCE_OP_RESET
  } bfce_op_t;

  typedef struct packed {
    bfce_op_t op;
    logic [17:0] addr;
    logic [7:0] data;
  } bfce_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic [17:0] addr;
  } bfce_pins_t;

endpackage

// ===== verification/bfce_flash_model.sv
// Behavioural flash device facing the host sequencer
`timescale 1ns/1ns
`default_nettype none
module bfce_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h71 // Arbitrary value
) (
  input wire logic MCLK,
  input wire bfce_pkg::bfce_pins_t PINS,
  input wire logic HV,
  input wire logic [7:0] DIN,
  output logic [7:0] DOUT,
  output logic DOE
);
  logic [7:0] mem [logic [17:0]];
  logic [7:0] keep [logic [17:0]];
  logic lock = 0, id = 0, tog = 0;
  logic [7:0] ld = 0;
  logic [14:0] a;
  logic wr_on;
  int st = 0, busy = 0;
  function automatic logic [7:0] rd(logic [17:0] x);
    return mem.exists(x) ? mem[x] : 8'hFF;
  endfunction
  assign DOE = !PINS.ce_n && !PINS.oe_n && PINS.reset_n;
  always @(posedge DOE) if (busy > 0) tog = ~tog;
  // Nonblocking so the host never samples a half-updated status byte
  always @(posedge MCLK) if (busy > 0) busy <= busy - 1;
  always @(negedge PINS.reset_n) begin
    st = 0;
    busy = 0;
    id = 0;
  end
  // Writes land when the strobe ends; chip-select may rise with it
  assign wr_on = !PINS.ce_n && !PINS.we_n && PINS.oe_n;
  always @(negedge wr_on)
    if (PINS.reset_n && busy == 0) begin
      a = PINS.addr[14:0];
      if (st == 3) begin
        if (!(lock && PINS.addr <= 18'h01FFF))
          mem[PINS.addr] = rd(PINS.addr) & DIN;
        ld = DIN;
        busy = 10;
        st = 0;
      end else if (DIN == 8'hF0 && (st == 0 || st == 2 && a == 15'h5555)) begin
        id = 0;
        st = 0;
      end else case (st)
        0, 4: st = (a == 15'h5555 && DIN == 8'hAA) ? st + 1 : 0;
        1, 5: st = (a == 15'h2AAA && DIN == 8'h55) ? st + 1 : 0;
        2: begin
          st = (a != 15'h5555) ? 0 : DIN == 8'hA0 ? 3 : DIN == 8'h80 ? 4 : 0;
          if (a == 15'h5555 && DIN == 8'h90) id = 1;
        end
        default: begin
          st = 0;
          if (a == 15'h5555 && DIN == 8'h10) begin
            keep.delete();
            foreach (mem[k]) if (lock && k <= 18'h01FFF) keep[k] = mem[k];
            mem = keep;
          end
          if (a == 15'h5555 && DIN == 8'h40) lock = 1;
          if (a == 15'h5555 && (DIN == 8'h10 || DIN == 8'h40)) begin
            ld = 8'hFF;
            busy = 30;
          end
        end
      endcase
    end
  always_comb begin
    if (busy > 0) DOUT = {~ld[7], tog, 6'h00};
    else if (HV || id)
      DOUT = PINS.addr[1:0] == 0 ? MAKER_CODE : PINS.addr[1:0] == 1 ?
        PART_CODE : {7'h00, lock};
    else DOUT = rd(PINS.addr);
  end
endmodule // bfce_flash_model
`default_nettype wire

// ===== verification/bfce_host_asserts.sv
// Pin protocol checks for the flash host sequencer
`timescale 1ns/1ns
`default_nettype none
module bfce_host_asserts #(
  parameter int PWRUP_CYC = 4
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire bfce_pkg::bfce_req_t REQ,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire bfce_pkg::bfce_pins_t PINS,
  input wire logic HV_ID_EN,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE
);
  int up_q;
  always_ff @(posedge MCLK) up_q <= !RSTN ? 0 : up_q + (up_q < 9999);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  read_strobe_a: assert property (
    REQ_VALID && REQ_READY && REQ.op == bfce_pkg::BFCE_OP_READ |->
    ##[1:3] !PINS.ce_n && !PINS.oe_n ##[1:3] RD_VALID) else $error("bad read");
  write_gate_a: assert property (
    !PINS.we_n |-> PINS.oe_n && !PINS.ce_n && DATA_OE) else $error("bad write");
  no_fight_a: assert property (
    !PINS.oe_n |-> PINS.we_n && !DATA_OE) else $error("bus fight");
  write_hold_a: assert property (
    !PINS.we_n |=> PINS.we_n && $stable(PINS.addr) && $stable(DATA_OUT))
    else $error("write strobe");
  reset_pulse_a: assert property (
    $fell(PINS.reset_n) |-> !PINS.reset_n [*4] ##[1:2] PINS.reset_n)
    else $error("reset pulse");
  pwrup_wait_a: assert property (
    REQ_READY |-> up_q >= PWRUP_CYC) else $error("early ready");
  idle_bus_a: assert property (
    REQ_READY |-> PINS.ce_n && PINS.we_n && PINS.oe_n && !DATA_OE)
    else $error("idle bus busy");
  take_once_a: assert property (
    REQ_VALID && REQ_READY |=> !REQ_READY) else $error("double take");
  hv_read_a: assert property (
    HV_ID_EN |-> PINS.we_n && PINS.reset_n) else $error("hv in write");
endmodule // bfce_host_asserts
bind bfce_host bfce_host_asserts #(.PWRUP_CYC(PWRUP_CYC)) chk_u (.MCLK(MCLK),
  .RSTN(RSTN), .REQ(REQ), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .RD_VALID(RD_VALID), .PINS(PINS), .HV_ID_EN(HV_ID_EN),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
`default_nettype wire

// ===== verification/byte_flash_command_engine_tb.sv
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ns
`default_nettype none
module byte_flash_command_engine_tb;
  logic mclk = 0, rstn = 0, req_valid = 0, lk = 0;
  logic req_ready, rd_valid, done, timeout, hv, data_oe, doe;
  logic [7:0] rd_data, data_out, dout, data_in, last_q = 0;
  logic [7:0] ref_m [logic [17:0]];
  logic [31:0] seed = 68646;
  bfce_pkg::bfce_req_t req = '0;
  bfce_pkg::bfce_pins_t pins;
  int miscompares = 0, samples_checked = 0;
  always #50 mclk = ~mclk;
  // Undriven bus toggles to the complement of its last value, never a stale byte
  assign data_in = data_oe ? data_out : doe ? dout : ~last_q;
  always @(posedge mclk) last_q <= data_in;
  bfce_host #(.PROG_CYC(100), .ERASE_CYC(200), .PWRUP_CYC(4)) dut_u (
    .MCLK(mclk), .RSTN(rstn), .REQ(req), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .DONE(done), .TIMEOUT(timeout), .PINS(pins), .HV_ID_EN(hv),
    .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe));
  bfce_flash_model flash_u (.MCLK(mclk), .PINS(pins), .HV(hv), .DIN(data_in),
    .DOUT(dout), .DOE(doe));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] exp_rd(logic [17:0] a);
    return ref_m.exists(a) ? ref_m[a] : 8'hFF;
  endfunction
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(bfce_pkg::bfce_op_t o, logic [17:0] a, logic [7:0] d,
    output logic [7:0] q, input logic to_exp = 1'b0);
    int n;
    @(posedge mclk);
    req <= '{o, a, d};
    req_valid <= 1'b1;
    n = 0;
    do @(negedge mclk); while (!req_ready && ++n < 500);
    @(posedge mclk);
    req_valid <= 1'b0;
    do @(negedge mclk); while (!(rd_valid || done || timeout) && ++n < 3000);
    q = rd_data;
    chk("completion", {6'h00, n >= 3000, timeout}, {7'h00, to_exp});
  endtask
  task automatic prog(logic [17:0] a, logic [7:0] d);
    logic [7:0] q, nv;
    nv = (lk && a < 18'h02000) ? exp_rd(a) : exp_rd(a) & d;
    // Poll waits for the written top bit; a cell that cannot take it times out
    op(bfce_pkg::BFCE_OP_PROGRAM, a, d, q, nv[7] != d[7]);
    ref_m[a] = nv;
  endtask
  task automatic rdchk(logic [17:0] a, logic [7:0] e, logic h = 0);
    logic [7:0] q;
    op(bfce_pkg::BFCE_OP_READ, a, {7'h00, h}, q);
    chk("read data", q, e);
  endtask
  task automatic results;
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    logic [7:0] q;
    logic [7:0] keep [logic [17:0]];
    logic [17:0] al [7];
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    al[6] = 18'h00100;
    prog(al[6], 8'h5A);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      al[i] = seed[17:0] | 18'h02000;
      prog(al[i], seed[31:24]);
      prog(al[i], seed[27:20]);
      rdchk(al[i], exp_rd(al[i]));
    end
    op(bfce_pkg::BFCE_OP_ID_ENTRY, 18'h05555, 8'h90, q);
    rdchk(18'h00000, flash_u.MAKER_CODE);
    rdchk(18'h00001, flash_u.PART_CODE);
    rdchk(18'h00002, 8'h00);
    op(bfce_pkg::BFCE_OP_ID_EXIT1, al[0], 8'hF0, q);
    rdchk(al[6], 8'h5A);
    op(bfce_pkg::BFCE_OP_LOCKOUT, 18'h05555, 8'h40, q);
    lk = 1;
    op(bfce_pkg::BFCE_OP_ID_ENTRY, 18'h05555, 8'h90, q);
    rdchk(18'h00002, 8'h01);
    op(bfce_pkg::BFCE_OP_ID_EXIT, 18'h05555, 8'hF0, q);
    prog(18'h01FFF, 8'h00);
    prog(al[6], 8'h00);
    rdchk(18'h01FFF, 8'hFF);
    op(bfce_pkg::BFCE_OP_ERASE, 18'h02000, 8'h10, q);
    foreach (ref_m[k]) if (k < 18'h02000) keep[k] = ref_m[k];
    ref_m = keep;
    foreach (al[i]) rdchk(al[i], exp_rd(al[i]));
    op(bfce_pkg::BFCE_OP_ID_ENTRY, 18'h05555, 8'h90, q);
    op(bfce_pkg::BFCE_OP_RESET, 18'h00000, 8'h00, q);
    rdchk(al[6], 8'h5A);
    rdchk(18'h00000, flash_u.MAKER_CODE, 1'b1);
    results();
  end
  // Whole run needs well under a millisecond of bus time
  initial begin
    #3000000;
    miscompares++;
    results();
  end
endmodule // byte_flash_command_engine_tb
`default_nettype wire
